// [hdl/operand_address_and_flags.sv]
/*
 * Operand address formation and status flag register of an 8-bit core.
 * Holds the flag and register pointer registers at their register-file
 * offsets and updates the flags from ALU results each cycle.
 * Assumes the decoder issues one flag operation per cycle and that the
 * register file routes writes to offsets 0xfc and 0xfd through here.
 */
//
// Behaviour
// - Register file locations use an 8-bit address over the whole range.
// - Memory addresses are 16 bits taken from register pairs.
// - Working address joins pointer upper nibble with 4-bit register number.
// - Register pair operands are even: 0-14 working, 4-238 absolute.
// - Register mode uses the named register contents as the operand.
// - Indirect mode uses register contents as address; pairs give 16 bits.
// - Indexed address is register address plus a working register.
// - Direct mode supplies the full next instruction address.
// - Relative target is next-instruction address plus signed 8-bit offset.
// - Immediate operand comes from the instruction operand field.
// - Flag register at 0xfc holds six status flags.
// - Two user flags change only by explicit writes and interrupt return.
// - Watchdog refresh forces zero to one, sign and overflow to zero.
// - Arithmetic carry reflects carry out of or borrow into bit 7.
// - Rotate and shift load carry with the last bit shifted out.
// - Carry can be set, cleared and inverted by dedicated operations.
// - Interrupt return reloads the whole flag register from the stack.
// - Arithmetic and logical results set zero when the result is zero.
// - Test under mask sets zero when the masked result is zero.
// - Rotate and shift set zero when the resulting byte is zero.
// - Sign copies the result's most significant bit.
// - Overflow flags signed range violations; logical operations clear it.
// - Decimal-adjust flag is set after subtraction and cleared after addition.
// - Half carry marks a carry or borrow at bit 3.
`timescale 1ns/1ps
module operand_address_and_flags #(
   parameter int CARRY_POS    = opflags_pkg::CARRY_POS,
   parameter int ZERO_POS     = opflags_pkg::ZERO_POS,
   parameter int SIGN_POS     = opflags_pkg::SIGN_POS,
   parameter int OVERFLOW_POS = opflags_pkg::OVERFLOW_POS,
   parameter int DECIMAL_POS  = opflags_pkg::DECIMAL_POS,
   parameter int HALF_POS     = opflags_pkg::HALF_POS,
   parameter int USER_TWO_POS = opflags_pkg::USER_TWO_POS,
   parameter int USER_ONE_POS = opflags_pkg::USER_ONE_POS
) (
   input  wire logic                        clk_i,
   input  wire logic                        srst_i,
   // Register-file port for the two mapped registers.
   input  wire logic                        reg_wr_i,
   input  wire logic [7:0]                  reg_addr_i,
   input  wire logic [7:0]                  reg_wdata_i,
   output logic      [7:0]                  reg_rdata_o,
   // Operand addressing.
   input  wire opflags_pkg::addr_mode_type  mode_i,
   input  wire logic                        addr_valid_i,
   input  wire logic [7:0]                  reg_field_i,
   input  wire logic [3:0]                  work_num_i,
   input  wire logic                        pair_op_i,
   input  wire logic                        pair_working_i,
   input  wire logic [7:0]                  index_value_i,
   input  wire logic [7:0]                  reg_value_i,
   input  wire logic [15:0]                 pair_value_i,
   input  wire logic [15:0]                 direct_i,
   input  wire logic [15:0]                 next_pc_i,
   input  wire logic [7:0]                  displacement_i,
   input  wire logic [7:0]                  immediate_i,
   output logic      [7:0]                  operand_reg_addr_o,
   output logic      [15:0]                 operand_mem_addr_o,
   output logic      [7:0]                  operand_value_o,
   output logic                             operand_done_o,
   output logic                             pair_error_o,
   // Flag update.
   input  wire opflags_pkg::flag_op_type    flag_op_i,
   input  wire logic [7:0]                  op_a_i,
   input  wire logic [7:0]                  op_b_i,
   input  wire logic                        carry_in_i,
   input  wire logic [7:0]                  result_i,
   input  wire logic                        shift_out_i,
   input  wire logic                        shift_overflow_i,
   input  wire logic [7:0]                  stack_flags_i,
   output logic      [7:0]                  status_flags_o,
   output logic      [7:0]                  working_group_pointer_o
);

   logic [7:0]  flags_q;
   logic [7:0]  flags_d;
   logic [7:0]  pointer_q;
   logic [8:0]  add_sum;
   logic [8:0]  sub_diff;
   logic [4:0]  add_low;
   logic [4:0]  sub_low;
   logic        add_ovf;
   logic        sub_ovf;
   logic        pair_bad_d;
   logic        flag_wr;
   logic        pointer_wr;

   function automatic logic is_hit(input logic [7:0] addr, input logic [7:0] offset);
      is_hit = (addr == offset);
   endfunction

   assign flag_wr    = reg_wr_i && is_hit(reg_addr_i, opflags_pkg::STATUS_FLAGS_OFFSET);
   assign pointer_wr = reg_wr_i && is_hit(reg_addr_i,
                                          opflags_pkg::WORKING_GROUP_POINTER_OFFSET);

   operand_address_unit u_addr (
      .clk_i          (clk_i),
      .srst_i         (srst_i),
      .mode_i         (mode_i),
      .valid_i        (addr_valid_i),
      .reg_field_i    (reg_field_i),
      .work_num_i     (work_num_i),
      .index_value_i  (index_value_i),
      .pointer_i      (pointer_q),
      .reg_value_i    (reg_value_i),
      .pair_value_i   (pair_value_i),
      .direct_i       (direct_i),
      .next_pc_i      (next_pc_i),
      .displacement_i (displacement_i),
      .immediate_i    (immediate_i),
      .reg_addr_o     (operand_reg_addr_o),
      .mem_addr_o     (operand_mem_addr_o),
      .operand_o      (operand_value_o),
      .done_o         (operand_done_o)
   );

   // A pair outside the legal even set is reported, not corrected.
   always_comb begin
      pair_bad_d = 1'b0;
      if (pair_op_i) begin
         if (reg_field_i[0]) begin
            pair_bad_d = 1'b1;
         end else if (pair_working_i) begin
            pair_bad_d = reg_field_i > opflags_pkg::PAIR_WORKING_MAX;
         end else begin
            pair_bad_d = (reg_field_i < opflags_pkg::PAIR_ABSOLUTE_MIN) ||
                         (reg_field_i > opflags_pkg::PAIR_ABSOLUTE_MAX);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pair_error_o <= 1'b0;
      end else begin
         pair_error_o <= addr_valid_i && pair_bad_d;
      end
   end

   assign add_sum  = {1'b0, op_a_i} + {1'b0, op_b_i} + {8'h00, carry_in_i};
   assign sub_diff = {1'b0, op_a_i} - {1'b0, op_b_i} - {8'h00, carry_in_i};
   assign add_low  = {1'b0, op_a_i[3:0]} + {1'b0, op_b_i[3:0]} + {4'h0, carry_in_i};
   assign sub_low  = {1'b0, op_a_i[3:0]} - {1'b0, op_b_i[3:0]} - {4'h0, carry_in_i};
   assign add_ovf  = (op_a_i[7] == op_b_i[7]) && (result_i[7] != op_a_i[7]);
   assign sub_ovf  = (op_a_i[7] != op_b_i[7]) && (result_i[7] != op_a_i[7]);

   // User flags are touched here only by interrupt return, otherwise only by a direct register write.
   always_comb begin
      flags_d = flags_q;
      case (flag_op_i)
         opflags_pkg::FOP_ADD: begin
            flags_d[CARRY_POS]    = add_sum[8];
            flags_d[ZERO_POS]     = (result_i == 8'h00);
            flags_d[SIGN_POS]     = result_i[7];
            flags_d[OVERFLOW_POS] = add_ovf;
            flags_d[DECIMAL_POS]  = 1'b0;
            flags_d[HALF_POS]     = add_low[4];
         end
         opflags_pkg::FOP_SUB: begin
            flags_d[CARRY_POS]    = sub_diff[8];
            flags_d[ZERO_POS]     = (result_i == 8'h00);
            flags_d[SIGN_POS]     = result_i[7];
            flags_d[OVERFLOW_POS] = sub_ovf;
            flags_d[DECIMAL_POS]  = 1'b1;
            flags_d[HALF_POS]     = sub_low[4];
         end
         opflags_pkg::FOP_LOGIC: begin
            flags_d[ZERO_POS]     = (result_i == 8'h00);
            flags_d[SIGN_POS]     = result_i[7];
            flags_d[OVERFLOW_POS] = 1'b0;
         end
         opflags_pkg::FOP_TEST: begin
            flags_d[ZERO_POS]     = (result_i == 8'h00);
            flags_d[SIGN_POS]     = result_i[7];
            flags_d[OVERFLOW_POS] = 1'b0;
         end
         opflags_pkg::FOP_ROTATE: begin
            flags_d[CARRY_POS]    = shift_out_i;
            flags_d[ZERO_POS]     = (result_i == 8'h00);
            flags_d[SIGN_POS]     = result_i[7];
            flags_d[OVERFLOW_POS] = shift_overflow_i;
         end
         opflags_pkg::FOP_CARRY_SET: begin
            flags_d[CARRY_POS] = 1'b1;
         end
         opflags_pkg::FOP_CARRY_CLR: begin
            flags_d[CARRY_POS] = 1'b0;
         end
         opflags_pkg::FOP_CARRY_INV: begin
            flags_d[CARRY_POS] = ~flags_q[CARRY_POS];
         end
         opflags_pkg::FOP_WATCHDOG: begin
            flags_d[ZERO_POS]     = 1'b1;
            flags_d[SIGN_POS]     = 1'b0;
            flags_d[OVERFLOW_POS] = 1'b0;
         end
         opflags_pkg::FOP_INTERRUPT_RETURN: begin
            flags_d = stack_flags_i;
         end
         default: begin
            flags_d = flags_q;
         end
      endcase
   end

   // An explicit register write overrides any flag effect in the same cycle.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flags_q <= opflags_pkg::STATUS_FLAGS_RESET;
      end else if (flag_wr) begin
         flags_q <= reg_wdata_i;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pointer_q <= opflags_pkg::WORKING_GROUP_POINTER_RESET;
      end else if (pointer_wr) begin
         pointer_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (is_hit(reg_addr_i, opflags_pkg::STATUS_FLAGS_OFFSET)) begin
         reg_rdata_o <= flags_q;
      end else if (is_hit(reg_addr_i, opflags_pkg::WORKING_GROUP_POINTER_OFFSET)) begin
         reg_rdata_o <= pointer_q;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   assign status_flags_o          = flags_q;
   assign working_group_pointer_o = pointer_q;

   chk_watchdog_flags: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_WATCHDOG && !flag_wr)
      |=> flags_q[ZERO_POS] && !flags_q[SIGN_POS] && !flags_q[OVERFLOW_POS])
      else $error("watchdog flags wrong");
   chk_add_carry: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_ADD && !flag_wr)
      |=> flags_q[CARRY_POS] == $past(add_sum[8]) && !flags_q[DECIMAL_POS])
      else $error("add carry or decimal wrong");
   chk_sub_decimal: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_SUB && !flag_wr) |=> flags_q[DECIMAL_POS])
      else $error("subtract decimal flag not set");
   chk_rotate_carry: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_ROTATE && !flag_wr)
      |=> flags_q[CARRY_POS] == $past(shift_out_i) &&
          flags_q[ZERO_POS] == ($past(result_i) == 8'h00))
      else $error("rotate carry or zero wrong");
   chk_interrupt_return_restore: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_INTERRUPT_RETURN && !flag_wr) |=> flags_q == $past(stack_flags_i))
      else $error("interrupt return restore wrong");
   chk_logic_overflow: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_LOGIC && !flag_wr)
      |=> !flags_q[OVERFLOW_POS] && flags_q[SIGN_POS] == $past(result_i[7]))
      else $error("logical overflow or sign wrong");
   chk_user_flags: assert property (@(posedge clk_i) disable iff (srst_i)
      !flag_wr |=> (flags_q[USER_ONE_POS] == $past(flags_q[USER_ONE_POS]) &&
                    flags_q[USER_TWO_POS] == $past(flags_q[USER_TWO_POS])) ||
                   $past(flag_op_i) == opflags_pkg::FOP_INTERRUPT_RETURN)
      else $error("user flag changed by operation");
   chk_carry_invert: assert property (@(posedge clk_i) disable iff (srst_i)
      (flag_op_i == opflags_pkg::FOP_CARRY_INV && !flag_wr)
      |=> flags_q[CARRY_POS] != $past(flags_q[CARRY_POS]))
      else $error("carry invert wrong");

endmodule

// [hdl/opflags_pkg.sv]
/*
 * Shared constants for the operand address and flag block: register
 * offsets, flag bit positions, reset values and operation encodings.
 * Assumes a single core clock and a synchronous active-high reset.
 */
package opflags_pkg;

   localparam logic [7:0] STATUS_FLAGS_OFFSET          = 8'hfc;
   localparam logic [7:0] WORKING_GROUP_POINTER_OFFSET = 8'hfd;

   localparam logic [7:0] STATUS_FLAGS_RESET           = 8'h00;
   localparam logic [7:0] WORKING_GROUP_POINTER_RESET  = 8'h00;

   // Default flag positions; the top module takes them as parameters.
   localparam int CARRY_POS     = 7;
   localparam int ZERO_POS      = 6;
   localparam int SIGN_POS      = 5;
   localparam int OVERFLOW_POS  = 4;
   localparam int DECIMAL_POS   = 3;
   localparam int HALF_POS      = 2;
   localparam int USER_TWO_POS  = 1;
   localparam int USER_ONE_POS  = 0;

   localparam logic [7:0] PAIR_WORKING_MAX  = 8'h0e;
   localparam logic [7:0] PAIR_ABSOLUTE_MIN = 8'h04;
   localparam logic [7:0] PAIR_ABSOLUTE_MAX = 8'hee;

   typedef enum logic [2:0] {
      MODE_REGISTER  = 3'h0,
      MODE_WORKING   = 3'h1,
      MODE_INDIRECT  = 3'h2,
      MODE_INDEXED   = 3'h3,
      MODE_DIRECT    = 3'h4,
      MODE_RELATIVE  = 3'h5,
      MODE_IMMEDIATE = 3'h6
   } addr_mode_type;

   typedef enum logic [3:0] {
      FOP_NONE      = 4'h0,
      FOP_ADD       = 4'h1,
      FOP_SUB       = 4'h2,
      FOP_LOGIC     = 4'h3,
      FOP_TEST      = 4'h4,
      FOP_ROTATE    = 4'h5,
      FOP_CARRY_SET = 4'h6,
      FOP_CARRY_CLR = 4'h7,
      FOP_CARRY_INV = 4'h8,
      FOP_WATCHDOG  = 4'h9,
      FOP_INTERRUPT_RETURN      = 4'ha
   } flag_op_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HOLD = 2'b10
   } addr_state_type;

endpackage

// [hdl/operand_address_unit.sv]
/*
 * Operand address former: combines mode, instruction fields, register
 * pointer and register contents into register or 16-bit memory addresses.
 * Assumes the register file supplies operand contents in the same cycle.
 */
`timescale 1ns/1ps
module operand_address_unit (
   input  wire logic                        clk_i,
   input  wire logic                        srst_i,
   input  wire opflags_pkg::addr_mode_type  mode_i,
   input  wire logic                        valid_i,
   input  wire logic [7:0]                  reg_field_i,
   input  wire logic [3:0]                  work_num_i,
   input  wire logic [7:0]                  index_value_i,
   input  wire logic [7:0]                  pointer_i,
   input  wire logic [7:0]                  reg_value_i,
   input  wire logic [15:0]                 pair_value_i,
   input  wire logic [15:0]                 direct_i,
   input  wire logic [15:0]                 next_pc_i,
   input  wire logic [7:0]                  displacement_i,
   input  wire logic [7:0]                  immediate_i,
   output logic      [7:0]                  reg_addr_o,
   output logic      [15:0]                 mem_addr_o,
   output logic      [7:0]                  operand_o,
   output logic                             done_o
);

   opflags_pkg::addr_state_type state_q;
   logic [7:0]  reg_addr_d;
   logic [15:0] mem_addr_d;
   logic [7:0]  operand_d;
   logic [7:0]  work_addr;

   assign work_addr = {pointer_i[7:4], work_num_i};

   always_comb begin
      reg_addr_d = reg_addr_o;
      mem_addr_d = mem_addr_o;
      operand_d  = operand_o;
      case (mode_i)
         opflags_pkg::MODE_REGISTER: begin
            reg_addr_d = reg_field_i;
            operand_d  = reg_value_i;
         end
         opflags_pkg::MODE_WORKING: begin
            reg_addr_d = work_addr;
            operand_d  = reg_value_i;
         end
         opflags_pkg::MODE_INDIRECT: begin
            reg_addr_d = reg_value_i;
            mem_addr_d = pair_value_i;
         end
         opflags_pkg::MODE_INDEXED: begin
            reg_addr_d = 8'(reg_field_i + index_value_i);
         end
         opflags_pkg::MODE_DIRECT: begin
            mem_addr_d = direct_i;
         end
         opflags_pkg::MODE_RELATIVE: begin
            mem_addr_d = 16'(next_pc_i + {{8{displacement_i[7]}}, displacement_i});
         end
         opflags_pkg::MODE_IMMEDIATE: begin
            operand_d = immediate_i;
         end
         default: begin
            operand_d = operand_o;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q    <= opflags_pkg::ST_IDLE;
         reg_addr_o <= 8'h00;
         mem_addr_o <= 16'h0000;
         operand_o  <= 8'h00;
         done_o     <= 1'b0;
      end else begin
         case (state_q)
            opflags_pkg::ST_IDLE: begin
               done_o <= valid_i;
               if (valid_i) begin
                  reg_addr_o <= reg_addr_d;
                  mem_addr_o <= mem_addr_d;
                  operand_o  <= operand_d;
                  state_q    <= opflags_pkg::ST_HOLD;
               end
            end
            opflags_pkg::ST_HOLD: begin
               done_o  <= 1'b0;
               state_q <= opflags_pkg::ST_IDLE;
            end
            default: begin
               done_o  <= 1'b0;
               state_q <= opflags_pkg::ST_IDLE;
            end
         endcase
      end
   end

   chk_relative_target: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_q == opflags_pkg::ST_IDLE && valid_i && mode_i == opflags_pkg::MODE_RELATIVE)
      |=> mem_addr_o == 16'($past(next_pc_i) + {{8{$past(displacement_i[7])}},
                                                $past(displacement_i)}))
      else $error("relative target wrong");
   chk_working_addr: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_q == opflags_pkg::ST_IDLE && valid_i && mode_i == opflags_pkg::MODE_WORKING)
      |=> reg_addr_o == {$past(pointer_i[7:4]), $past(work_num_i)})
      else $error("working address wrong");
   chk_indexed_addr: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_q == opflags_pkg::ST_IDLE && valid_i && mode_i == opflags_pkg::MODE_INDEXED)
      |=> reg_addr_o == 8'($past(reg_field_i) + $past(index_value_i)))
      else $error("indexed address wrong");
   chk_done_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
      done_o |=> !done_o)
      else $error("done longer than one cycle");

endmodule

// [testbench/testbench.sv]
/*
 * Self-checking bench for the operand address and flag block.
 * Assumes the default flag positions of opflags_pkg and a 5 ns core clock.
 */
`timescale 1ns/1ps
module testbench;
   logic        clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, addr_valid_i = 1'b0;
   logic        pair_op_i = 1'b0, pair_working_i = 1'b0, carry_in_i = 1'b0;
   logic        shift_out_i = 1'b0, shift_overflow_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_field_i = 8'h00;
   logic [7:0]  index_value_i = 8'h00, reg_value_i = 8'h00, displacement_i = 8'h00;
   logic [7:0]  immediate_i = 8'h00, op_a_i = 8'h00, op_b_i = 8'h00, result_i = 8'h00;
   logic [7:0]  stack_flags_i = 8'h00;
   logic [3:0]  work_num_i = 4'h0;
   logic [15:0] pair_value_i = 16'h0000, direct_i = 16'h0000, next_pc_i = 16'h0000;
   opflags_pkg::addr_mode_type mode_i = opflags_pkg::MODE_REGISTER;
   opflags_pkg::flag_op_type   flag_op_i = opflags_pkg::FOP_NONE;
   logic [7:0]  reg_rdata_o, operand_reg_addr_o, operand_value_o;
   logic [7:0]  status_flags_o, working_group_pointer_o;
   logic [15:0] operand_mem_addr_o;
   logic        operand_done_o, pair_error_o;
   int          err_total = 0, checks_done = 0;

   operand_address_and_flags operand_address_and_flags_inst (.clk_i, .srst_i, .reg_wr_i,
      .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .mode_i, .addr_valid_i, .reg_field_i,
      .work_num_i, .pair_op_i, .pair_working_i, .index_value_i, .reg_value_i,
      .pair_value_i, .direct_i, .next_pc_i, .displacement_i, .immediate_i,
      .operand_reg_addr_o, .operand_mem_addr_o, .operand_value_o, .operand_done_o,
      .pair_error_o, .flag_op_i, .op_a_i, .op_b_i, .carry_in_i, .result_i, .shift_out_i,
      .shift_overflow_i, .stack_flags_i, .status_flags_o, .working_group_pointer_o);

   always #2.5 clk_i = ~clk_i;

   task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // A flag operation may ride along with the write to test which one wins.
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input opflags_pkg::flag_op_type op);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      flag_op_i <= op;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      flag_op_i <= opflags_pkg::FOP_NONE;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      @(posedge clk_i);
      #1;
      cmp(reg_rdata_o, e);
   endtask

   // Operand a doubles as the saved flag image for interrupt return.
   task automatic fop(input opflags_pkg::flag_op_type op, input logic [7:0] a, b, r,
                      input logic so, sov, input logic [7:0] e);
      @(posedge clk_i);
      flag_op_i <= op;
      op_a_i <= a;
      op_b_i <= b;
      result_i <= r;
      shift_out_i <= so;
      shift_overflow_i <= sov;
      stack_flags_i <= a;
      @(posedge clk_i);
      flag_op_i <= opflags_pkg::FOP_NONE;
      #1;
      cmp(status_flags_o, e);
   endtask

   // One data word feeds every content input so that no input stays constant.
   task automatic areq(input opflags_pkg::addr_mode_type m, input logic [7:0] f,
                       input logic [3:0] wn, input logic pop, pw, input logic [15:0] d,
                       input logic [7:0] disp, input logic e);
      int n;
      @(posedge clk_i);
      mode_i <= m;
      reg_field_i <= f;
      work_num_i <= wn;
      pair_op_i <= pop;
      pair_working_i <= pw;
      reg_value_i <= d[7:0];
      index_value_i <= d[7:0];
      pair_value_i <= d;
      direct_i <= d;
      next_pc_i <= d;
      immediate_i <= d[15:8];
      displacement_i <= disp;
      addr_valid_i <= 1'b1;
      @(posedge clk_i);
      addr_valid_i <= 1'b0;
      #1;
      n = 0;
      while (operand_done_o !== 1'b1 && n < 4) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n == 4) begin
         err_total++;
         $display("CHECK FAILED at %0t: no completion", $time);
         end_sim();
      end
      cmp(pair_error_o, e);
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      #1;
      cmp(status_flags_o, opflags_pkg::STATUS_FLAGS_RESET);
      cmp(working_group_pointer_o, opflags_pkg::WORKING_GROUP_POINTER_RESET);
      wr(8'hfd, 8'h5a, opflags_pkg::FOP_NONE);
      cmp(working_group_pointer_o, 8'h5a);
      rd(8'hfd, 8'h5a);
      rd(8'h10, 8'h00);
      wr(8'hfc, 8'h03, opflags_pkg::FOP_NONE);
      rd(8'hfc, 8'h03);
      $display("test registers finished");
      areq(opflags_pkg::MODE_REGISTER, 8'hff, 4'h0, 1'b0, 1'b0, 16'h009c, 8'h00, 1'b0);
      cmp(operand_reg_addr_o, 8'hff);
      cmp(operand_value_o, 8'h9c);
      areq(opflags_pkg::MODE_WORKING, 8'h00, 4'h3, 1'b0, 1'b0, 16'h0011, 8'h00, 1'b0);
      cmp(operand_reg_addr_o, 8'h53);
      cmp(operand_value_o, 8'h11);
      areq(opflags_pkg::MODE_INDIRECT, 8'h20, 4'h0, 1'b0, 1'b0, 16'h1234, 8'h00, 1'b0);
      cmp(operand_reg_addr_o, 8'h34);
      cmp(operand_mem_addr_o, 16'h1234);
      areq(opflags_pkg::MODE_INDEXED, 8'hf0, 4'h0, 1'b0, 1'b0, 16'h0020, 8'h00, 1'b0);
      cmp(operand_reg_addr_o, 8'h10);
      areq(opflags_pkg::MODE_DIRECT, 8'h00, 4'h0, 1'b0, 1'b0, 16'hbeef, 8'h00, 1'b0);
      cmp(operand_mem_addr_o, 16'hbeef);
      areq(opflags_pkg::MODE_RELATIVE, 8'h00, 4'h0, 1'b0, 1'b0, 16'h0100, 8'hfe, 1'b0);
      cmp(operand_mem_addr_o, 16'h00fe);
      areq(opflags_pkg::MODE_RELATIVE, 8'h00, 4'h0, 1'b0, 1'b0, 16'hfff0, 8'h7f, 1'b0);
      cmp(operand_mem_addr_o, 16'h006f);
      areq(opflags_pkg::MODE_IMMEDIATE, 8'h00, 4'h0, 1'b0, 1'b0, 16'h3c00, 8'h00, 1'b0);
      cmp(operand_value_o, 8'h3c);
      areq(opflags_pkg::MODE_REGISTER, 8'h04, 4'h4, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b0);
      areq(opflags_pkg::MODE_REGISTER, 8'h03, 4'h3, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
      areq(opflags_pkg::MODE_REGISTER, 8'h02, 4'h2, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
      areq(opflags_pkg::MODE_REGISTER, 8'hee, 4'he, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b0);
      areq(opflags_pkg::MODE_REGISTER, 8'hf0, 4'h0, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
      areq(opflags_pkg::MODE_WORKING, 8'h0e, 4'he, 1'b1, 1'b1, 16'h0000, 8'h00, 1'b0);
      areq(opflags_pkg::MODE_WORKING, 8'h0f, 4'hf, 1'b1, 1'b1, 16'h0000, 8'h00, 1'b1);
      $display("test addressing finished");
      fop(opflags_pkg::FOP_ADD, 8'hff, 8'h01, 8'h00, 1'b0, 1'b0, 8'hc7);
      fop(opflags_pkg::FOP_SUB, 8'h00, 8'h01, 8'hff, 1'b0, 1'b0, 8'haf);
      fop(opflags_pkg::FOP_ADD, 8'h7f, 8'h01, 8'h80, 1'b0, 1'b0, 8'h37);
      fop(opflags_pkg::FOP_LOGIC, 8'hf0, 8'h0f, 8'h00, 1'b0, 1'b0, 8'h47);
      fop(opflags_pkg::FOP_CARRY_SET, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'hc7);
      fop(opflags_pkg::FOP_CARRY_INV, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h47);
      fop(opflags_pkg::FOP_CARRY_INV, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'hc7);
      fop(opflags_pkg::FOP_CARRY_CLR, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h47);
      fop(opflags_pkg::FOP_ROTATE, 8'h80, 8'h00, 8'h00, 1'b1, 1'b0, 8'hc7);
      fop(opflags_pkg::FOP_ROTATE, 8'h03, 8'h00, 8'h81, 1'b0, 1'b1, 8'h37);
      fop(opflags_pkg::FOP_WATCHDOG, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h47);
      fop(opflags_pkg::FOP_TEST, 8'h80, 8'h80, 8'h80, 1'b0, 1'b0, 8'h27);
      fop(opflags_pkg::FOP_SUB, 8'h10, 8'h01, 8'h0f, 1'b0, 1'b0, 8'h0f);
      fop(opflags_pkg::FOP_ADD, 8'h01, 8'h01, 8'h02, 1'b0, 1'b0, 8'h03);
      // The carry input must reach both the carry and the half carry terms.
      @(posedge clk_i);
      carry_in_i <= 1'b1;
      fop(opflags_pkg::FOP_ADD, 8'h0f, 8'h00, 8'h10, 1'b0, 1'b0, 8'h07);
      fop(opflags_pkg::FOP_SUB, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0, 8'haf);
      @(posedge clk_i);
      carry_in_i <= 1'b0;
      fop(opflags_pkg::FOP_INTERRUPT_RETURN, 8'h5c, 8'h00, 8'h00, 1'b0, 1'b0, 8'h5c);
      wr(8'hfc, 8'ha0, opflags_pkg::FOP_CARRY_SET);
      cmp(status_flags_o, 8'ha0);
      $display("test flags finished");
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      #1;
      cmp(status_flags_o, opflags_pkg::STATUS_FLAGS_RESET);
      cmp(working_group_pointer_o, opflags_pkg::WORKING_GROUP_POINTER_RESET);
      cmp(operand_mem_addr_o, 16'h0000);
      areq(opflags_pkg::MODE_WORKING, 8'h00, 4'h9, 1'b0, 1'b0, 16'h0042, 8'h00, 1'b0);
      cmp(operand_reg_addr_o, 8'h09);
      cmp(operand_value_o, 8'h42);
      $display("test reset finished");
      end_sim();
   end
endmodule
